//--- inc/tws_pkg.sv
// Purpose: Shared constants and types of the two-wire register access slave
// Assumes: 100 MHz system clock, serial clock far slower than it
// Notes:   Device addresses are the full 8-bit address byte values
package tws_pkg;

  // Address bytes answered, chosen by the address select strap
  localparam logic [7:0] WR_ADDR_STRAP_LO = 8'h0090; // Write, strap low
  localparam logic [7:0] RD_ADDR_STRAP_LO = 8'h0091; // Read, strap low
  localparam logic [7:0] WR_ADDR_STRAP_HI = 8'h00BA; // Write, strap high
  localparam logic [7:0] RD_ADDR_STRAP_HI = 8'h00BB; // Read, strap high

  // Address byte layout
  localparam int         DEV_ADDR_MSB = 7;          // Top of 7-bit address
  localparam int         DEV_ADDR_LSB = 1;          // Bottom of 7-bit address
  localparam int         DIR_BIT      = 0;          // Direction bit
  localparam logic       DIR_READ     = 1'b1;       // 1 requests a read

  // Byte framing
  localparam int         BYTE_W       = 8;          // Bits per byte
  localparam logic [3:0] BYTE_BITS    = 4'h8;       // Bits before ack slot
  localparam int         REG_ADDR_W   = 16;         // Register address width

  // Input conditioning
  localparam int         SYNC_STAGES  = 2;          // Synchroniser depth
  localparam int         FILT_LEN     = 2;          // Agreeing samples needed

  // Serial clock limit against the pixel clock, host side bound
  localparam int         SCL_PIX_DIV  = 22;         // Pixel clock divisor

  // Index of the byte received after a write address byte
  localparam logic [1:0] IDX_ADDR_HI  = 2'h0;       // Register address high
  localparam logic [1:0] IDX_ADDR_LO  = 2'h1;       // Register address low
  localparam logic [1:0] IDX_DATA     = 2'h2;       // Write data bytes

  // Link state machine
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEVADDR, ST_DEVACK, ST_RXBYTE,
    ST_RXACK, ST_TXBYTE, ST_TXACK, ST_IGNORE
  } tws_state_t;

endpackage : tws_pkg

//--- design/tws_pin_filt.sv
// Purpose: Synchronise and deglitch asynchronous pin inputs
// Assumes: Idle level of every input is high
// Notes:   Output changes only after FILT samples agree
`timescale 1ns/1ps
`default_nettype none
module tws_pin_filt #(
  parameter int W    = 2,                     // Number of inputs
  parameter int FILT = tws_pkg::FILT_LEN      // Agreeing samples needed
) (
  input  wire logic         clk_sys,          // System clock
  input  wire logic         rstn,             // Async reset, active low
  input  wire logic [W-1:0] raw_in,           // Pins from outside
  output logic      [W-1:0] clean_out         // Filtered levels
);
  import tws_pkg::*;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic            meta_r;               // First stage, read by sync_r only
      logic            sync_r;               // Second stage
      logic [FILT-1:0] hist_r;               // Recent synchronised samples
      logic            clean_r;              // Filtered level of this bit

      // Two-stage synchroniser, reset to idle high
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          meta_r <= 1'b1;
          sync_r <= 1'b1;
        end else begin
          meta_r <= raw_in[gi];
          sync_r <= meta_r;
        end
      end

      // History feeds a hysteresis filter; short spikes never pass
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          hist_r  <= '1;
          clean_r <= 1'b1;
        end else begin
          hist_r <= {hist_r[FILT-2:0], sync_r};
          if (&hist_r) begin
            clean_r <= 1'b1;
          end else if (~|hist_r) begin
            clean_r <= 1'b0;
          end
        end
      end

      // One writer per bit keeps the output vector single-driven
      assign clean_out[gi] = clean_r;
    end
  endgenerate

endmodule : tws_pin_filt
`default_nettype wire

//--- design/tws_shift_byte.sv
// Purpose: Byte shift register, MSB first, shared by receive and send
// Assumes: load and shift never in the same cycle
// Notes:   Load wins if both come together
`timescale 1ns/1ps
`default_nettype none
module tws_shift_byte #(
  parameter int W = tws_pkg::BYTE_W           // Register width
) (
  input  wire logic         clk_sys,          // System clock
  input  wire logic         rstn,             // Async reset, active low
  input  wire logic         load,             // Parallel load strobe
  input  wire logic [W-1:0] load_val,         // Value to load
  input  wire logic         shift,            // Shift strobe
  input  wire logic         bit_in,           // Bit entering at LSB
  output logic      [W-1:0] data              // Register contents
);
  import tws_pkg::*;

  // Shift left so the MSB leaves first
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      data <= '0;
    end else if (load) begin
      data <= load_val;
    end else if (shift) begin
      data <= {data[W-2:0], bit_in};
    end
  end

endmodule : tws_shift_byte
`default_nettype wire

//--- design/tws_slave.sv
// Purpose: Two-wire serial slave giving access to a 16-bit register space
// Assumes: Host drives the serial clock; register data ready with read pulse
// Notes:   Data line is open drain: drive low with sda_oe, release otherwise
// Function
// - First byte: 7-bit address on top, LSB 0 write, 1 read.
// - Strap low: answer address bytes 0x90 write, 0x91 read.
// - Strap high: answer address bytes 0xBA write, 0xBB read.
// - After each byte transmitter releases data; receiver pulls low to acknowledge.
// - Data left high in acknowledge slot means no-acknowledge.
// - Data rising while clock high is stop; ends the transaction.
// - Acknowledge the address byte only when it matches our address.
// - Write carries 16-bit register address, high byte first, each acknowledged.
// - Acknowledge each write data byte, then step the register address.
// - Random read: address write without data, then repeated start.
// - After read address byte, send bytes from the loaded address.
// - Host acknowledges read bytes; address steps after each sent byte.
// - Host no-acknowledge ends a read; release the data line then.
// - Read without address write returns current register address.
// - Sequential read continues over successive addresses until no-acknowledge.
// - Single write: address byte, two register address bytes, one data byte.
// - Data falling while clock high is a start or repeated start.
// - Bytes go MSB first, one bit per clock; data moves while low.
`timescale 1ns/1ps
`default_nettype none
module tws_slave #(
  parameter int AW = tws_pkg::REG_ADDR_W      // Register address width
) (
  input  wire logic          clk_sys,               // System clock, 100 MHz
  input  wire logic          rstn,                  // Async reset, active low
  input  wire logic          scl_in,                // Serial clock pin
  input  wire logic          sda_in,                // Data pin level
  output logic               sda_out,               // Data drive level
  output logic               sda_oe,                // Data drive enable
  input  wire logic          address_select_strap,  // Address select strap
  output logic [AW-1:0]      reg_addr,              // Register address
  output logic               reg_wr_pulse,          // Write strobe
  output logic [7:0]         reg_wr_data,           // Write data
  output logic               reg_rd_pulse,          // Read strobe
  input  wire logic [7:0]    reg_rd_data            // Read data, valid on strobe
);
  import tws_pkg::*;

  tws_state_t  state_r;             // Link state
  tws_state_t  state_nxt;           // Next link state
  logic [2:0]  pins_f;              // Filtered strap, data, clock
  logic        scl_f;               // Filtered clock
  logic        sda_f;               // Filtered data
  logic        strap_f;             // Filtered strap
  logic        scl_q;               // Clock one cycle back
  logic        sda_q;               // Data one cycle back
  logic        scl_rise;            // Clock rising
  logic        scl_fall;            // Clock falling
  logic        start_det;           // Start or repeated start
  logic        stop_det;            // Stop
  logic [3:0]  bit_cnt_r;           // Bits of current byte
  logic        byte_end;            // Falling edge after eighth bit
  logic        in_byte;             // State shifts bits
  logic [7:0]  shift_data;          // Shift register contents
  logic [7:0]  own_wr_addr;         // Selected write address byte
  logic        dev_match;           // Address byte is ours
  logic        dir_rd_r;            // Current transfer is a read
  logic        ack_seen_r;          // Host acknowledged last byte
  logic [1:0]  rx_idx_r;            // Index of received byte
  logic        sda_oe_r;            // Drive enable register
  logic        wr_pulse_r;          // Write strobe register
  logic [7:0]  wr_data_r;           // Write data register
  logic        rd_pulse_r;          // Read strobe register
  logic [AW-1:0] addr_r;            // Internal register address

  // Pins pass two flops and a filter before any logic here
  tws_pin_filt #(
    .W    (3),
    .FILT (FILT_LEN)
  ) u_filt (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .raw_in    ({address_select_strap, sda_in, scl_in}),
    .clean_out (pins_f)
  );

  assign scl_f   = pins_f[0];
  assign sda_f   = pins_f[1];
  assign strap_f = pins_f[2];

  // Previous filtered levels for edge finding
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  // Edges and bus conditions
  assign scl_rise  = scl_f & ~scl_q;
  assign scl_fall  = ~scl_f & scl_q;
  assign start_det = scl_f & scl_q & sda_q & ~sda_f;
  assign stop_det  = scl_f & scl_q & ~sda_q & sda_f;
  assign byte_end  = scl_fall && (bit_cnt_r == BYTE_BITS);
  assign in_byte   = (state_r == ST_DEVADDR) || (state_r == ST_RXBYTE) ||
                     (state_r == ST_TXBYTE);

  // Address compare ignores direction; strap picks the pair
  assign own_wr_addr = strap_f ? WR_ADDR_STRAP_HI : WR_ADDR_STRAP_LO;
  assign dev_match   = shift_data[DEV_ADDR_MSB:DEV_ADDR_LSB] ==
                       own_wr_addr[DEV_ADDR_MSB:DEV_ADDR_LSB];

  // Shared byte shifter: samples on rise, sends MSB first
  tws_shift_byte #(
    .W (BYTE_W)
  ) u_shift (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .load     (rd_pulse_r),
    .load_val (reg_rd_data),
    .shift    (scl_rise && in_byte),
    .bit_in   (sda_f),
    .data     (shift_data)
  );

  // Next state; stop and start override everything
  always_comb begin
    state_nxt = state_r;
    if (stop_det) begin
      state_nxt = ST_IDLE;
    end else if (start_det) begin
      state_nxt = ST_DEVADDR;
    end else if (scl_fall) begin
      unique case (state_r)
        ST_DEVADDR: begin
          if (byte_end) begin
            state_nxt = dev_match ? ST_DEVACK : ST_IGNORE;
          end
        end
        ST_DEVACK: begin
          state_nxt = dir_rd_r ? ST_TXBYTE : ST_RXBYTE;
        end
        ST_RXBYTE: begin
          if (byte_end) begin
            state_nxt = ST_RXACK;
          end
        end
        ST_RXACK: begin
          state_nxt = ST_RXBYTE;
        end
        ST_TXBYTE: begin
          if (byte_end) begin
            state_nxt = ST_TXACK;
          end
        end
        ST_TXACK: begin
          state_nxt = ack_seen_r ? ST_TXBYTE : ST_IGNORE;
        end
        ST_IDLE, ST_IGNORE: begin
          state_nxt = state_r;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Bit counter restarts with every new byte or slot
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_r <= '0;
    end else if (start_det || (scl_fall && (state_nxt != state_r))) begin
      bit_cnt_r <= '0;
    end else if (scl_rise && in_byte) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  // Direction latched from the address byte
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dir_rd_r <= 1'b0;
    end else if (state_r == ST_DEVADDR && byte_end) begin
      dir_rd_r <= shift_data[DIR_BIT] == DIR_READ;
    end
  end

  // Host answer sampled while clock is high in its slot
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_seen_r <= 1'b0;
    end else if (state_r == ST_TXACK && scl_rise) begin
      ack_seen_r <= ~sda_f;
    end else if (state_r != ST_TXACK) begin
      ack_seen_r <= 1'b0;
    end
  end

  // Data drive changes only on clock fall, start or stop, so it is stable while high otherwise
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sda_oe_r <= 1'b0;
    end else if (stop_det || start_det) begin
      sda_oe_r <= 1'b0;
    end else if (scl_fall) begin
      sda_oe_r <= (state_nxt == ST_DEVACK) || (state_nxt == ST_RXACK) ||
                  (state_nxt == ST_TXBYTE && !shift_data[BYTE_W-1]);
    end
  end

  // Index of received bytes; restarts after every start
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_idx_r <= IDX_ADDR_HI;
    end else if (start_det) begin
      rx_idx_r <= IDX_ADDR_HI;
    end else if (state_r == ST_RXBYTE && byte_end && rx_idx_r != IDX_DATA) begin
      rx_idx_r <= rx_idx_r + 2'h1;
    end
  end

  // Write strobe with data, one cycle, address held steady during it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_pulse_r <= 1'b0;
      wr_data_r  <= '0;
    end else begin
      wr_pulse_r <= state_r == ST_RXBYTE && byte_end && rx_idx_r == IDX_DATA;
      if (state_r == ST_RXBYTE && byte_end && rx_idx_r == IDX_DATA) begin
        wr_data_r <= shift_data;
      end
    end
  end

  // Read strobe: after our read address byte, or after host ack
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_pulse_r <= 1'b0;
    end else begin
      rd_pulse_r <= (state_r == ST_DEVADDR && byte_end && dev_match &&
                     shift_data[DIR_BIT] == DIR_READ) ||
                    (state_r == ST_TXACK && scl_rise && !sda_f);
    end
  end

  // Register address: loaded high then low, stepped after each data byte
  // It survives stops so a bare read continues where the last left off
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      addr_r <= '0;
    end else if (state_r == ST_RXBYTE && byte_end && rx_idx_r == IDX_ADDR_HI) begin
      addr_r[AW-1:AW-8] <= shift_data;
    end else if (state_r == ST_RXBYTE && byte_end && rx_idx_r == IDX_ADDR_LO) begin
      addr_r[7:0] <= shift_data;
    end else if (wr_pulse_r) begin
      addr_r <= addr_r + AW'(1);
    end else if (state_r == ST_TXBYTE && byte_end) begin
      addr_r <= addr_r + AW'(1);
    end
  end

  // Outputs straight from flops; open drain pulls low only
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  assign sda_oe       = sda_oe_r;
  assign reg_addr     = addr_r;
  assign reg_wr_pulse = wr_pulse_r;
  assign reg_wr_data  = wr_data_r;
  assign reg_rd_pulse = rd_pulse_r;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence addr_byte_done_s;
    state_r == ST_DEVADDR && byte_end;
  endsequence

  sequence rx_byte_done_s;
    state_r == ST_RXBYTE && byte_end;
  endsequence

  sequence host_nack_s;
    state_r == ST_TXACK && scl_fall && !ack_seen_r;
  endsequence

  match_ack_a: assert property (
    addr_byte_done_s ##0 dev_match |=> sda_oe_r && state_r == ST_DEVACK)
    else $error("matching address not acknowledged");

  strap_lo_rd_a: assert property (
    addr_byte_done_s ##0 (!strap_f && shift_data == RD_ADDR_STRAP_LO) |=> rd_pulse_r)
    else $error("strap low read address not served");

  strap_hi_wr_a: assert property (
    addr_byte_done_s ##0 (strap_f && shift_data == WR_ADDR_STRAP_HI) |=> state_r == ST_DEVACK)
    else $error("strap high write address not taken");

  mismatch_quiet_a: assert property (
    addr_byte_done_s ##0 !dev_match |=> (!sda_oe_r) [*8])
    else $error("data driven after address mismatch");

  rx_ack_a: assert property (
    rx_byte_done_s |=> sda_oe_r ##1 (sda_oe_r throughout (!scl_fall [*2])))
    else $error("received byte not acknowledged");

  wr_step_a: assert property (
    reg_wr_pulse |=> reg_addr == $past(reg_addr) + 1'b1)
    else $error("address not stepped after write");

  addr_hi_a: assert property (
    rx_byte_done_s ##0 rx_idx_r == IDX_ADDR_HI |=> reg_addr[AW-1:AW-8] == $past(shift_data))
    else $error("high address byte not loaded");

  nack_release_a: assert property (
    host_nack_s |=> !sda_oe_r && state_r == ST_IGNORE)
    else $error("data not released on no-acknowledge");

  stop_idle_a: assert property (
    stop_det |=> state_r == ST_IDLE && !sda_oe_r)
    else $error("stop did not end the transaction");

  tx_bit_a: assert property (
    state_r == ST_TXBYTE && scl_fall && bit_cnt_r < BYTE_BITS |=>
      sda_oe_r == !$past(shift_data[BYTE_W-1]))
    else $error("sent bit does not match shifter MSB");

  hold_high_a: assert property (
    scl_f && scl_q && !start_det && !stop_det |=> $stable(sda_oe_r))
    else $error("data drive changed while clock high");

endmodule : tws_slave
`default_nettype wire

//--- testbench/tws_host_model.sv
// Purpose: Behavioural host master driving the two-wire slave
// Assumes: Serial clock period of eight system clocks, low six, high two
// Notes:   Data is only pulled low; the bench pull-up gives the high level
`timescale 1ns/1ps
`default_nettype none
module tws_host_model (
  input  wire logic clk_sys,   // Paces the serial clock
  input  wire logic sda,       // Resolved data wire
  output var  logic scl,       // Serial clock, idle high
  output var  logic sda_pull   // High pulls the data wire low
);
  // Bus idle from time zero
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end
  // Every change lands just after a system clock edge
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : w
  // Start or repeated start: data falls while clock high
  task automatic start();
    w(3);
    sda_pull <= 1'b0;
    w(3);
    scl      <= 1'b1;
    w(3);
    sda_pull <= 1'b1;
    w(3);
    scl      <= 1'b0;
  endtask : start
  // Stop: data rises while clock high
  task automatic stop();
    w(3);
    sda_pull <= 1'b1;
    w(3);
    scl      <= 1'b1;
    w(3);
    sda_pull <= 1'b0;
    w(3);
  endtask : stop
  // One bit in 80 ns; slave drive lands by the rise, read one clock later
  task automatic xfer_bit(input logic b, output logic r);
    w(3);
    sda_pull <= ~b;
    w(3);
    scl      <= 1'b1;
    w(1);
    r = sda;
    w(1);
    scl      <= 1'b0;
  endtask : xfer_bit
  // Byte out MSB first, then release for the slave's acknowledge
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer_bit(b[i], r);
    xfer_bit(1'b1, r);
    ack = ~r;
  endtask : put_byte
  // Byte in MSB first; acknowledge asks for more, release ends the read
  task automatic get_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer_bit(1'b1, d[i]);
    xfer_bit(~more, r);
  endtask : get_byte
endmodule : tws_host_model
`default_nettype wire

//--- testbench/tws_slave_tb.sv
// Purpose: Self-checking bench for the two-wire register access slave
// Assumes: Register file modelled as a fixed function of the address
// Notes:   Address table first, then write, read, restart and reset cases
`timescale 1ns/1ps
`default_nettype none
module tws_slave_tb;
  import tws_pkg::*;
  typedef struct packed {
    logic       strap;
    logic [7:0] abyte;
    logic       ack;
  } tws_row_t;
  logic        clk_sys              = 1'b0;
  logic        rstn                 = 1'b0;
  logic        address_select_strap = 1'b0;
  logic        scl;
  logic        host_pull;
  logic        sda_wire;
  logic        sda_out;
  logic        sda_oe;
  logic [15:0] reg_addr;
  logic        reg_wr_pulse;
  logic [7:0]  reg_wr_data;
  logic        reg_rd_pulse;
  logic [7:0]  rd_data;
  logic [23:0] wr_log[$];
  logic [15:0] cur                  = 16'h0000;
  int          num_errors           = 0;
  int          comparisons          = 0;
  int          rd_pulses            = 0;
  int          gets                 = 0;
  tws_row_t    rows[8]              = '{
    '{1'b0, WR_ADDR_STRAP_LO, 1'b1}, '{1'b0, RD_ADDR_STRAP_LO, 1'b1},
    '{1'b1, WR_ADDR_STRAP_HI, 1'b1}, '{1'b1, RD_ADDR_STRAP_HI, 1'b1},
    '{1'b0, WR_ADDR_STRAP_HI, 1'b0}, '{1'b1, RD_ADDR_STRAP_LO, 1'b0},
    '{1'b0, 8'h92, 1'b0}, '{1'b1, 8'hBC, 1'b0}};
  // Register contents seen by reads
  function automatic logic [7:0] rd_val(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : rd_val
  // Clock, open-drain wire with pull-up, register read data
  always #5 clk_sys = ~clk_sys;
  assign sda_wire = (host_pull | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;
  assign rd_data  = rd_val(reg_addr);
  // Every write strobe is logged, every read strobe counted
  always @(posedge clk_sys) begin
    if (reg_wr_pulse === 1'b1)
      wr_log.push_back({reg_addr, reg_wr_data});
    if (reg_rd_pulse === 1'b1)
      rd_pulses++;
  end
  tws_slave i_tws_slave (
    .clk_sys(clk_sys), .rstn(rstn), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .address_select_strap(address_select_strap),
    .reg_addr(reg_addr), .reg_wr_pulse(reg_wr_pulse), .reg_wr_data(reg_wr_data),
    .reg_rd_pulse(reg_rd_pulse), .reg_rd_data(rd_data));
  tws_host_model i_tws_host_model (
    .clk_sys(clk_sys), .sda(sda_wire), .scl(scl), .sda_pull(host_pull));
  // Compare helpers: each check counted, each mismatch reported at once
  task automatic fail(input string what);
    num_errors++;
    $display("mismatch at %0t: %s", $time, what);
  endtask : fail
  task automatic chk_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp)
      fail(what);
  endtask : chk_bit
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
      fail(what);
  endtask : chk_byte
  task automatic chk_wr(input logic [23:0] got, input logic [23:0] exp, input string what);
    comparisons++;
    if (got !== exp)
      fail(what);
  endtask : chk_wr
  task automatic chk_cnt(input int got, input int exp, input string what);
    comparisons++;
    if (got != exp)
      fail(what);
  endtask : chk_cnt
  // Link wrappers: send with expected acknowledge, read with expected data
  task automatic put(input logic [7:0] b, input logic exp_ack);
    logic ack;
    i_tws_host_model.put_byte(b, ack);
    chk_bit(ack, exp_ack, "acknowledge");
  endtask : put
  task automatic get(input logic more);
    logic [7:0] d;
    i_tws_host_model.get_byte(more, d);
    gets++;
    chk_byte(d, rd_val(cur), "read data");
    cur = cur + 16'h0001;
  endtask : get
  task automatic chk_log(input logic [23:0] exp);
    logic [23:0] got;
    got = 24'hxx_xxxx;
    if (wr_log.size() > 0)
      got = wr_log.pop_front();
    chk_wr(got, exp, "write record");
  endtask : chk_log
  task automatic strap_to(input logic s);
    address_select_strap <= s;
    repeat (6) @(posedge clk_sys);
  endtask : strap_to
  task automatic tally_and_finish();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // Hang guard
  initial begin
    repeat (30000) @(posedge clk_sys);
    fail("run did not finish");
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    chk_bit(sda_oe, 1'b0, "oe in reset");
    chk_bit(sda_out, 1'b0, "drive level in reset");
    chk_wr({reg_addr, 8'h00}, 24'h00_0000, "addr in reset");
    rstn <= 1'b1;
    repeat (8) @(posedge clk_sys);
    // Address table; read rows fetch from the current location
    foreach (rows[i]) begin
      strap_to(rows[i].strap);
      i_tws_host_model.start();
      put(rows[i].abyte, rows[i].ack);
      if (!rows[i].ack)
        put(8'h00, 1'b0);
      else if (rows[i].abyte[0])
        get(1'b0);
      i_tws_host_model.stop();
    end
    // Sequential write across a low-byte carry, ended by stop
    strap_to(1'b1);
    i_tws_host_model.start();
    put(WR_ADDR_STRAP_HI, 1'b1);
    put(8'h00, 1'b1);
    put(8'hFF, 1'b1);
    put(8'hA5, 1'b1);
    put(8'h3C, 1'b1);
    i_tws_host_model.stop();
    chk_log(24'h00_FFA5);
    chk_log(24'h01_003C);
    // Random read, three bytes, last one refused
    strap_to(1'b0);
    i_tws_host_model.start();
    put(WR_ADDR_STRAP_LO, 1'b1);
    put(8'h12, 1'b1);
    put(8'h34, 1'b1);
    i_tws_host_model.start();
    put(RD_ADDR_STRAP_LO, 1'b1);
    cur = 16'h1234;
    get(1'b1);
    get(1'b1);
    get(1'b0);
    repeat (6) @(posedge clk_sys);
    chk_bit(sda_oe, 1'b0, "released after refusal");
    i_tws_host_model.stop();
    // Single write ended by a repeated start, then read from the stepped address
    i_tws_host_model.start();
    put(WR_ADDR_STRAP_LO, 1'b1);
    put(8'h00, 1'b1);
    put(8'h20, 1'b1);
    put(8'h77, 1'b1);
    i_tws_host_model.start();
    put(RD_ADDR_STRAP_LO, 1'b1);
    cur = 16'h0021;
    get(1'b0);
    i_tws_host_model.stop();
    chk_log(24'h00_2077);
    // Reset in mid-transfer, then current-location read from zero
    i_tws_host_model.start();
    put(WR_ADDR_STRAP_LO, 1'b1);
    put(8'h56, 1'b1);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk_bit(sda_oe, 1'b0, "oe in mid reset");
    chk_wr({reg_addr, 8'h00}, 24'h00_0000, "addr in mid reset");
    rstn <= 1'b1;
    i_tws_host_model.stop();
    repeat (8) @(posedge clk_sys);
    i_tws_host_model.start();
    put(RD_ADDR_STRAP_LO, 1'b1);
    cur = 16'h0000;
    get(1'b0);
    i_tws_host_model.stop();
    chk_bit(sda_out, 1'b0, "drive level");
    chk_cnt(rd_pulses, gets, "read strobes");
    tally_and_finish();
  end
endmodule : tws_slave_tb
`default_nettype wire
